// File: hdl/progseq.sv
// Contract
// RULE1: Keep a 10-bit program counter holding the address of the next instruction.
// RULE2: A plain instruction advances the counter by its own length.
// RULE3: A taken jump of any of the five kinds loads the operand target.
// RULE4: A call saves the counter into the return register, then loads the target.
// RULE5: A return loads the counter from the return register.
// RULE6: Every reset puts the program counter at address zero.
// RULE7: The one-bit stack level pointer increments on call, decrements on return.
// RULE8: Reset clears the stack level pointer.
// RULE9: Stack overflow or underflow raises a system reset and zeroes the counter.
// RULE10: Only call, return and reset change the stack level pointer.
// RULE11: Return register is 10 bits; its low byte is the last data register.
// RULE12: A return leaves the return register unchanged.
// RULE13: Reset leaves the return register contents as they were.
// RULE14: Data access to the last data register spoils the return register top bits.
// RULE15: Program memory is word-addressed by the counter; depth depends on variant.
// RULE16: Addresses 3EAH to 3FFH are a reserved test area.
// RULE17: Reaching unmounted space or the test area sends control to address zero.
// RULE18: A low reset pin resets the processor; the pin has a pull-up.
// RULE19: A power-on-clear reset drives the reset pin low while it lasts.
// RULE20: No execution while any reset is asserted; first fetch follows release.
`timescale 1ns/10ps
`default_nettype none
`include "progseq_regs.svh"

module progseq #(
  parameter logic [10:0] DEPTH = `PS_DEPTH_LARGE
) (
  input  wire logic                 i_clk,
  input  wire logic                 i_srst,
  input  wire logic                 i_reset_pin_in,
  input  wire logic                 i_poc_trigger,
  input  wire logic                 i_exec,
  input  wire progseq_pkg::progseq_op_e i_op,
  input  wire logic [1:0]           i_len,
  input  wire logic                 i_taken,
  input  wire logic [9:0]           i_target,
  input  wire logic                 i_rf_wr,
  input  wire logic                 i_rf_rd,
  input  wire logic [7:0]           i_rf_wdata,
  output logic [9:0]                o_program_counter,
  output logic                      o_fetch_en,
  output logic                      o_stack_level_pointer,
  output logic [9:0]                o_return_address_register,
  output logic [7:0]                o_last_data_register,
  output logic                      o_sys_reset,
  output logic                      o_reset_pin_out,
  output logic                      o_reset_pin_oe
);

  progseq_pkg::progseq_s q;
  progseq_pkg::progseq_s d;
  logic       any_reset;
  logic [9:0] seq_addr;
  logic [9:0] next_addr;
  logic       stack_fault;

  // Unmounted space and the reserved test area both count as unusable.
  function automatic logic addr_usable(input logic [9:0] a);
    logic ok;
    ok = ({1'b0, a} < DEPTH);
    if ((a >= `PS_TEST_LO) && (a <= `PS_TEST_HI)) begin // RULE16
      ok = 1'b0;
    end
    return ok;
  endfunction

  always_comb begin
    d           = q;
    any_reset   = !q.pin_high || q.poc_active;
    seq_addr    = 10'(q.program_counter + {8'h00, i_len});
    next_addr   = seq_addr;
    stack_fault = 1'b0;
    d.sys_reset = 1'b0;
    d.pin_out   = 1'b0;
    // A pin change is believed only once the second and third stages agree.
    d.pin_sync  = {q.pin_sync[1:0], i_reset_pin_in};
    d.poc_sync  = {q.poc_sync[1:0], i_poc_trigger};
    if (q.pin_sync[1] == q.pin_sync[2]) begin
      d.pin_high = q.pin_sync[2];
    end
    if (q.poc_sync[1] == q.poc_sync[2]) begin
      d.poc_active = q.poc_sync[2];
    end
    d.pin_oe = d.poc_active; // RULE19
    // The low byte is one storage cell with the last data register.
    if (i_rf_wr) begin
      d.return_address_register[7:0] = i_rf_wdata; // RULE11
    end
    // The top bits are not part of the data cell; they are zeroed, a legal undefined value.
    if (i_rf_wr || i_rf_rd) begin
      d.return_address_register[9:8] = 2'h0; // RULE14
    end
    case (q.st)
      progseq_pkg::PS_ST_RESET: begin
        d.program_counter     = `PS_PC_RESET; // RULE20
        d.stack_level_pointer = `PS_SP_RESET;
        d.fetch_en            = 1'b0;
        if (!any_reset) begin
          d.st       = progseq_pkg::PS_ST_RUN;
          d.fetch_en = 1'b1; // RULE20
        end
      end
      progseq_pkg::PS_ST_RUN: begin
        if (any_reset) begin
          d.st                  = progseq_pkg::PS_ST_RESET; // RULE18
          d.program_counter     = `PS_PC_RESET; // RULE6
          d.stack_level_pointer = `PS_SP_RESET; // RULE8
          d.fetch_en            = 1'b0;
        end else if (i_exec) begin
          case (i_op)
            progseq_pkg::PS_OP_JUMP: begin
              if (i_taken) begin
                next_addr = i_target; // RULE3
              end
            end
            progseq_pkg::PS_OP_CALL: begin
              if (q.stack_level_pointer) begin
                stack_fault = 1'b1; // RULE9
              end else begin
                d.return_address_register = seq_addr; // RULE4
                d.stack_level_pointer     = 1'b1; // RULE7
                next_addr                 = i_target; // RULE4
              end
            end
            progseq_pkg::PS_OP_RET: begin
              if (!q.stack_level_pointer) begin
                stack_fault = 1'b1; // RULE9
              end else begin
                d.stack_level_pointer = 1'b0; // RULE7
                next_addr             = q.return_address_register; // RULE5
              end
            end
            default: begin
              next_addr = seq_addr; // RULE2
            end
          endcase
          if (stack_fault) begin
            d.st                  = progseq_pkg::PS_ST_FAULT;
            d.program_counter     = `PS_PC_RESET; // RULE9
            d.stack_level_pointer = `PS_SP_RESET;
            d.fetch_en            = 1'b0;
            d.sys_reset           = 1'b1;
          end else if (addr_usable(next_addr)) begin
            d.program_counter = next_addr; // RULE1
          end else begin
            d.program_counter = `PS_PC_RESET; // RULE17
          end
        end
      end
      progseq_pkg::PS_ST_FAULT: begin
        d.program_counter = `PS_PC_RESET;
        d.st              = any_reset ? progseq_pkg::PS_ST_RESET : progseq_pkg::PS_ST_RUN;
        d.fetch_en        = !any_reset;
      end
      default: begin
        d.st = progseq_pkg::PS_ST_RESET;
      end
    endcase
    // The return register survives every reset; no reset, the power-up one included, gives it a value.
    if (i_srst) begin
      d.st                  = progseq_pkg::PS_ST_RESET;
      d.program_counter     = `PS_PC_RESET; // RULE6
      d.stack_level_pointer = `PS_SP_RESET; // RULE8
      d.pin_sync            = `PS_PIN_SYNC_RST;
      d.poc_sync            = `PS_POC_SYNC_RST;
      d.pin_high            = 1'b1;
      d.poc_active          = 1'b0;
      d.pin_oe              = 1'b0;
      d.fetch_en            = 1'b0;
      d.sys_reset           = 1'b0;
      d.return_address_register = q.return_address_register; // RULE13
    end
  end

  always_ff @(posedge i_clk) begin
    q <= d;
  end

  // The power-up value of the return register is left open on purpose.
  assign o_program_counter         = q.program_counter; // RULE15
  assign o_fetch_en                = q.fetch_en;
  assign o_stack_level_pointer     = q.stack_level_pointer;
  assign o_return_address_register = q.return_address_register;
  assign o_last_data_register      = q.return_address_register[7:0];
  assign o_sys_reset               = q.sys_reset;
  assign o_reset_pin_out           = q.pin_out;
  assign o_reset_pin_oe            = q.pin_oe;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);

  logic run_exec;
  assign run_exec = (q.st == progseq_pkg::PS_ST_RUN) && !any_reset && i_exec;

  a_step_advance: assert property ( // RULE2
    run_exec && i_op == progseq_pkg::PS_OP_STEP && addr_usable(seq_addr)
    |=> o_program_counter == $past(seq_addr))
    else $error("plain step did not advance by length");
  a_jump_load: assert property ( // RULE3
    run_exec && i_op == progseq_pkg::PS_OP_JUMP && i_taken && addr_usable(i_target)
    |=> o_program_counter == $past(i_target))
    else $error("taken jump did not load target");
  a_call_save: assert property ( // RULE4
    run_exec && i_op == progseq_pkg::PS_OP_CALL && !o_stack_level_pointer && !i_rf_wr
    && !i_rf_rd |=> o_return_address_register == $past(seq_addr) && o_stack_level_pointer)
    else $error("call did not save return address");
  a_ret_restore: assert property ( // RULE5
    run_exec && i_op == progseq_pkg::PS_OP_RET && o_stack_level_pointer
    && addr_usable(o_return_address_register) && !i_rf_wr && !i_rf_rd
    |=> o_program_counter == $past(o_return_address_register)
    && $stable(o_return_address_register))
    else $error("return did not restore counter");
  a_fault_reset: assert property ( // RULE9
    run_exec && ((i_op == progseq_pkg::PS_OP_CALL) == o_stack_level_pointer)
    && (i_op == progseq_pkg::PS_OP_CALL || i_op == progseq_pkg::PS_OP_RET)
    |=> o_sys_reset && o_program_counter == `PS_PC_RESET ##1 !o_sys_reset)
    else $error("stack fault did not raise one-cycle system reset");
  a_sp_only_flow: assert property ( // RULE10
    !run_exec && !any_reset && q.st == progseq_pkg::PS_ST_RUN |=> $stable(o_stack_level_pointer))
    else $error("stack pointer moved without call or return");
  a_test_area: assert property ( // RULE17
    o_fetch_en |-> addr_usable(o_program_counter))
    else $error("counter inside unmounted or test area");
  a_hold_reset: assert property ( // RULE20
    q.st == progseq_pkg::PS_ST_RESET |-> !o_fetch_en && o_program_counter == `PS_PC_RESET
    && !o_stack_level_pointer)
    else $error("execution while reset held");
  a_pin_reset: assert property ( // RULE18
    $fell(q.pin_high) |=> q.st == progseq_pkg::PS_ST_RESET [*2])
    else $error("low reset pin did not reset processor");
  a_poc_drive: assert property ( // RULE19
    q.poc_active |-> o_reset_pin_oe && !o_reset_pin_out)
    else $error("power-on-clear did not drive reset pin low");
  a_rf_share: assert property ( // RULE11
    i_rf_wr && !run_exec |=> o_last_data_register == $past(i_rf_wdata)
    && o_return_address_register[9:8] == 2'h0)
    else $error("last data register write lost");

  // Strobes on the shared data cell are excluded where they may rightly move it.
  a_reset_pc_zero: assert property ( // RULE6
    any_reset && q.st == progseq_pkg::PS_ST_RUN
    |=> o_program_counter == `PS_PC_RESET && q.st == progseq_pkg::PS_ST_RESET)
    else $error("reset did not return counter to zero");
  a_reset_sp_clear: assert property ( // RULE8
    any_reset |=> !o_stack_level_pointer)
    else $error("reset did not clear stack level pointer");
  a_call_incr: assert property ( // RULE7
    run_exec && i_op == progseq_pkg::PS_OP_CALL && !o_stack_level_pointer
    |=> o_stack_level_pointer)
    else $error("call did not raise stack level pointer");
  a_ret_decr: assert property ( // RULE7
    run_exec && i_op == progseq_pkg::PS_OP_RET && o_stack_level_pointer
    |=> !o_stack_level_pointer)
    else $error("return did not lower stack level pointer");
  a_ret_keeps: assert property ( // RULE12
    run_exec && i_op == progseq_pkg::PS_OP_RET && !i_rf_wr && !i_rf_rd
    |=> $stable(o_return_address_register))
    else $error("return altered return register");
  a_reset_keeps: assert property ( // RULE13
    any_reset && !i_rf_wr && !i_rf_rd |=> $stable(o_return_address_register))
    else $error("reset altered return register");
  a_rf_read_top: assert property ( // RULE14
    i_rf_rd && !i_rf_wr && !run_exec
    |=> o_return_address_register[9:8] == 2'h0 && $stable(o_last_data_register))
    else $error("data read did not settle return register top bits");
  a_call_wins: assert property ( // RULE11
    run_exec && i_op == progseq_pkg::PS_OP_CALL && !o_stack_level_pointer && i_rf_wr
    |=> o_return_address_register == $past(seq_addr))
    else $error("data write overrode call return address");
  a_test_jump: assert property ( // RULE16
    run_exec && i_op == progseq_pkg::PS_OP_JUMP && i_taken && i_target >= `PS_TEST_LO
    |=> o_program_counter == `PS_PC_RESET)
    else $error("jump into test area was not sent to zero");
  a_unmounted: assert property ( // RULE17
    run_exec && i_op == progseq_pkg::PS_OP_STEP && !addr_usable(seq_addr)
    |=> o_program_counter == `PS_PC_RESET)
    else $error("step into unusable space was not sent to zero");
  a_pin_idle: assert property ( // RULE19
    !q.poc_active |-> !o_reset_pin_oe)
    else $error("reset pin driven without power-on-clear");
  a_fault_resume: assert property ( // RULE9
    o_sys_reset && !any_reset
    |=> o_fetch_en && o_program_counter == `PS_PC_RESET)
    else $error("system reset did not restart at zero");
  a_first_fetch: assert property ( // RULE20
    q.st == progseq_pkg::PS_ST_RESET && !any_reset
    |=> o_fetch_en && o_program_counter == `PS_PC_RESET)
    else $error("first fetch did not follow reset release");
  a_pin_release: assert property ( // RULE18
    $rose(q.pin_high) && !q.poc_active
    |-> q.st == progseq_pkg::PS_ST_RESET ##1 o_fetch_en)
    else $error("pin release did not restart execution");

  c_call_ret: cover property (run_exec && i_op == progseq_pkg::PS_OP_CALL
    ##[1:20] run_exec && i_op == progseq_pkg::PS_OP_RET);
  c_overflow: cover property (o_sys_reset);
  c_test_hit: cover property (run_exec && !addr_usable(seq_addr));
  c_poc: cover property (o_reset_pin_oe ##[1:10] !o_reset_pin_oe);
  c_pin_reset: cover property ($fell(q.pin_high) ##[2:12] o_fetch_en);

endmodule

`default_nettype wire

// File: include/progseq_regs.svh
`ifndef PROGSEQ_REGS_SVH
`define PROGSEQ_REGS_SVH

// Address width of the program counter and of the return address register.
`define PS_ADDR_W       10
// Address of the first instruction fetched after any reset.
`define PS_PC_RESET     10'h000
// Reset value of the stack level pointer.
`define PS_SP_RESET     1'h0
// Bounds of the reserved test program area, both inclusive.
`define PS_TEST_LO      10'h3EA
`define PS_TEST_HI      10'h3FF
// Mounted program depths of the three variants.
`define PS_DEPTH_SMALL  11'h200
`define PS_DEPTH_MID    11'h300
`define PS_DEPTH_LARGE  11'h3EA
// Idle value of the reset pin synchroniser, pin high means no reset.
`define PS_PIN_SYNC_RST 3'h7
`define PS_POC_SYNC_RST 3'h0

`endif

// File: include/progseq_pkg.sv
`default_nettype none

package progseq_pkg;

  typedef enum logic [1:0] {
    PS_ST_RESET = 2'h0,
    PS_ST_RUN   = 2'h1,
    PS_ST_FAULT = 2'h3
  } progseq_state_e;

  typedef enum logic [1:0] {
    PS_OP_STEP = 2'h0,
    PS_OP_JUMP = 2'h1,
    PS_OP_CALL = 2'h2,
    PS_OP_RET  = 2'h3
  } progseq_op_e;

  typedef struct packed {
    progseq_state_e st;
    logic [9:0]     program_counter;
    logic           stack_level_pointer;
    logic [9:0]     return_address_register;
    logic [2:0]     pin_sync;
    logic [2:0]     poc_sync;
    logic           pin_high;
    logic           poc_active;
    logic           pin_oe;
    logic           pin_out;
    logic           fetch_en;
    logic           sys_reset;
  } progseq_s;

endpackage

`default_nettype wire

// File: verification/progseq_rom.sv
`timescale 1ns/10ps
`default_nettype none

// Every address answers with a word, so a stray fetch never sees a floating bus.
module progseq_rom (
  input  wire logic [9:0] i_addr,
  output logic      [9:0] o_word
);
  assign o_word = i_addr ^ 10'h2A5;
endmodule

`default_nettype wire

// File: verification/progseq_tb_top.sv
`timescale 1ns/10ps
`default_nettype none

module progseq_tb_top;
  localparam progseq_pkg::progseq_op_e OP_STEP = progseq_pkg::PS_OP_STEP;
  localparam progseq_pkg::progseq_op_e OP_JUMP = progseq_pkg::PS_OP_JUMP;
  localparam progseq_pkg::progseq_op_e OP_CALL = progseq_pkg::PS_OP_CALL;
  localparam progseq_pkg::progseq_op_e OP_RET  = progseq_pkg::PS_OP_RET;
  logic                     clk       = 1'b0;
  logic                     srst      = 1'b1;
  logic                     pin_drv_n = 1'b1;
  logic                     power_on_clear       = 1'b0;
  logic                     exec      = 1'b0;
  progseq_pkg::progseq_op_e op        = OP_STEP;
  logic [1:0]               len       = 2'h1;
  logic                     taken     = 1'b0;
  logic [9:0]               tgt       = 10'h000;
  logic                     rf_wr     = 1'b0;
  logic                     rf_rd     = 1'b0;
  logic [7:0]               rf_wdata  = 8'h00;
  logic [9:0]               pc;
  logic [9:0]               ras;
  logic [9:0]               word;
  logic [7:0]               ldr;
  logic                     fetch;
  logic                     sp;
  logic                     sysr;
  logic                     pin_out;
  logic                     pin_oe;
  wire                      pin_wire;
  int                       fail_count      = 0;
  int                       samples_checked = 0;

  always #50 clk = ~clk;

  // The pull-up wins whenever neither the bench nor the device pulls the pin.
  assign pin_wire = pin_drv_n & (pin_oe ? pin_out : 1'b1);

  progseq u_dut (
    .i_clk                     (clk),
    .i_srst                    (srst),
    .i_reset_pin_in            (pin_wire),
    .i_poc_trigger             (power_on_clear),
    .i_exec                    (exec),
    .i_op                      (op),
    .i_len                     (len),
    .i_taken                   (taken),
    .i_target                  (tgt),
    .i_rf_wr                   (rf_wr),
    .i_rf_rd                   (rf_rd),
    .i_rf_wdata                (rf_wdata),
    .o_program_counter         (pc),
    .o_fetch_en                (fetch),
    .o_stack_level_pointer     (sp),
    .o_return_address_register (ras),
    .o_last_data_register      (ldr),
    .o_sys_reset               (sysr),
    .o_reset_pin_out           (pin_out),
    .o_reset_pin_oe            (pin_oe)
  );

  progseq_rom u_rom (
    .i_addr (pc),
    .o_word (word)
  );

  task automatic check(input string name, input logic [9:0] exp, input logic [9:0] got);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic run(input progseq_pkg::progseq_op_e o, input logic [1:0] l,
                     input logic t, input logic [9:0] a);
    @(posedge clk);
    exec <= 1'b1;
    op <= o;
    len <= l;
    taken <= t;
    tgt <= a;
    @(posedge clk);
    exec <= 1'b0;
    #1;
  endtask

  task automatic rf_access(input logic wr, input logic rd, input logic [7:0] d);
    @(posedge clk);
    rf_wr <= wr;
    rf_rd <= rd;
    rf_wdata <= d;
    @(posedge clk);
    rf_wr <= 1'b0;
    rf_rd <= 1'b0;
    #1;
  endtask

  task automatic wait_fetch(input logic lvl);
    int n;
    n = 0;
    while (fetch !== lvl && n < 20) begin
      @(posedge clk);
      #1;
      n++;
    end
    check("fetch_en", {9'h0, lvl}, {9'h0, fetch});
  endtask

  task automatic t_reset_and_step();
    #1;
    check("pc_in_reset", 10'h000, pc);
    check("fetch_in_reset", 10'h000, {9'h0, fetch});
    check("sp_in_reset", 10'h000, {9'h0, sp});
    @(posedge clk);
    srst <= 1'b0;
    wait_fetch(1'b1);
    run(OP_STEP, 2'h1, 1'b0, 10'h000);
    check("pc_step1", 10'h001, pc);
    check("rom_word", 10'h001 ^ 10'h2A5, word);
    run(OP_STEP, 2'h2, 1'b0, 10'h000);
    check("pc_step2", 10'h003, pc);
  endtask

  task automatic t_jump_call_ret();
    run(OP_JUMP, 2'h2, 1'b1, 10'h040);
    check("pc_jump", 10'h040, pc);
    run(OP_JUMP, 2'h2, 1'b0, 10'h200);
    check("pc_nojump", 10'h042, pc);
    run(OP_CALL, 2'h2, 1'b1, 10'h100);
    check("pc_call", 10'h100, pc);
    check("ras_call", 10'h044, ras);
    check("sp_call", 10'h001, {9'h0, sp});
    run(OP_RET, 2'h1, 1'b0, 10'h155);
    check("pc_ret", 10'h044, pc);
    check("ras_ret", 10'h044, ras);
    check("sp_ret", 10'h000, {9'h0, sp});
  endtask

  task automatic t_stack_fault();
    run(OP_CALL, 2'h2, 1'b1, 10'h080);
    run(OP_CALL, 2'h2, 1'b1, 10'h090);
    check("sysr_over", 10'h001, {9'h0, sysr});
    check("pc_over", 10'h000, pc);
    check("sp_over", 10'h000, {9'h0, sp});
    wait_fetch(1'b1);
    run(OP_RET, 2'h1, 1'b0, 10'h000);
    check("sysr_under", 10'h001, {9'h0, sysr});
    check("pc_under", 10'h000, pc);
    wait_fetch(1'b1);
  endtask

  task automatic t_test_area_and_rf();
    run(OP_JUMP, 2'h1, 1'b1, 10'h3E9);
    run(OP_STEP, 2'h1, 1'b0, 10'h000);
    check("pc_test_area", 10'h000, pc);
    run(OP_JUMP, 2'h1, 1'b1, 10'h3F0);
    check("pc_test_jump", 10'h000, pc);
    run(OP_JUMP, 2'h1, 1'b1, 10'h2F0);
    run(OP_CALL, 2'h2, 1'b1, 10'h010);
    check("ras_high", 10'h2F2, ras);
    rf_access(1'b0, 1'b1, 8'h00);
    check("ras_read", 10'h0F2, ras);
    check("ldr_read", 10'h0F2, {2'h0, ldr});
    rf_access(1'b1, 1'b0, 8'hAB);
    check("ldr_write", 10'h0AB, {2'h0, ldr});
    check("ras_shared", 10'h0AB, ras);
    run(OP_RET, 2'h1, 1'b0, 10'h000);
    check("pc_ret_data", 10'h0AB, pc);
  endtask

  task automatic t_pin_and_poc();
    @(posedge clk);
    pin_drv_n <= 1'b0;
    wait_fetch(1'b0);
    check("pc_pin", 10'h000, pc);
    check("ras_pin", 10'h0AB, ras);
    @(posedge clk);
    pin_drv_n <= 1'b1;
    wait_fetch(1'b1);
    @(posedge clk);
    power_on_clear <= 1'b1;
    wait_fetch(1'b0);
    repeat (2) @(posedge clk);
    #1;
    check("pin_oe_poc", 10'h001, {9'h0, pin_oe});
    check("pin_wire_poc", 10'h000, {9'h0, pin_wire});
    @(posedge clk);
    power_on_clear <= 1'b0;
    wait_fetch(1'b1);
    check("pin_oe_idle", 10'h000, {9'h0, pin_oe});
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    repeat (7) @(posedge clk);
    t_reset_and_step();
    t_jump_call_ret();
    t_stack_fault();
    t_test_area_and_rf();
    t_pin_and_poc();
    report_and_stop();
  end

  // The whole sequence needs under a hundred cycles; thirty times that means a hang.
  initial begin
    repeat (3000) @(posedge clk);
    fail_count++;
    report_and_stop();
  end
endmodule

`default_nettype wire
